// *** src/tolk_regs.sv ***
// tolk_regs: save-lock, lock status, vm id compare and id extension regs.
// assumes: one 20 MHz clock, synchronous active-high reset, master that
// never overlaps read and write strobes and expects data one cycle later.
`timescale 1ns/1ps
`default_nettype none

module tolk_regs
	import tolk_pkg::*;
#(
	parameter bit          HAS_LOCK     = 1'b1,
	parameter bit          HAS_VIRT     = 1'b1,
	parameter bit          SWAP_ORDER   = 1'b0,
	parameter bit          ERET_ORDER   = 1'b0,
	parameter bit          PD_LEVEL_HI  = 1'b0,
	parameter bit          PD_LEVEL_LO  = 1'b1
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        seq_step_i,
	input  wire logic        powered_down_i,
	input  wire logic [7:0]  virtual_machine_id_current_i,
	output logic      [31:0] rdata_o,
	output logic             rvalid_o,
	output logic             error_o,
	output logic             lock_o,
	output logic      [7:0]  seq_count_o,
	output logic      [31:0] trace_ctrl_o,
	output logic             virtual_machine_id_match_o
);

	// ***********************************************************
	// behaviour notes
	// ***********************************************************
	// the lock guards only vm id and trace ctrl; the key, status,
	//   id ext and counter offsets stay reachable while locked
	// any non-key write to the key offset unlocks, so a stray
	//   write there opens the trace registers again
	// reset always leaves the lock set; software unlocks first
	// the sequence counter is 8 bits and wraps; longer save or
	//   restore sequences are not tracked past that
	// the locked bit shows its real value while powered down,
	//   although software may not rely on it then
	// the key needs a full 32-bit write; there are no byte lanes
	// answers come exactly one cycle after the strobe, never stalled
	// read data is zero in every cycle that answers no read
	// unmapped offsets read zero and ignore writes, with no error
	// an unlocked bank answers every access without error
	// the compare result lags the id inputs by one cycle
	// identification fields and the status power-down bits are fixed by parameters
	// the powered-down input only holds the compare result off

	// ***********************************************************
	// register state
	// ***********************************************************
	// lock state, set by the key and by reset
	logic        lock_ff;
	logic        nxt_lock;
	// save/restore sequence counter
	logic [7:0]  seq_ff;
	logic [7:0]  nxt_seq;
	// stored virtual machine id for the exact compare
	logic [7:0]  virtual_machine_id_ff;
	logic [7:0]  nxt_virtual_machine_id;
	// stand-in trace register guarded by the lock
	logic [31:0] ctrl_ff;
	logic [31:0] nxt_ctrl;
	// registered compare result
	logic        match_ff;
	logic        nxt_match;
	// registered answer: read data, valid, error
	tolk_rsp_t   rsp_ff;
	tolk_rsp_t   nxt_rsp;

	// ***********************************************************
	// request decode
	// ***********************************************************
	tolk_req_t req;
	logic      sel_virtual_machine_id;
	logic      sel_id_ext;
	logic      sel_key;
	logic      sel_status;
	logic      sel_ctrl;
	logic      sel_seq;
	logic      any_access;
	logic      is_trace_reg;
	logic      refused;
	logic      key_write;
	logic      reg_write;

	// gather the port into one request word
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// one select per register offset
	always_comb begin
		sel_virtual_machine_id   = (req.addr == OFF_VIRTUAL_MACHINE_ID_CMP);
		sel_id_ext = (req.addr == OFF_ID_EXT);
		sel_key    = (req.addr == OFF_LOCK_KEY);
		sel_status = (req.addr == OFF_LOCK_STATUS);
		sel_ctrl   = (req.addr == OFF_TRACE_CTRL);
		sel_seq    = (req.addr == OFF_SEQ_COUNT);
	end

	// trace registers are the ones the lock guards; the key register
	// itself stays open so that software can always unlock
	always_comb begin
		any_access   = req.wr || req.rd;
		is_trace_reg = sel_virtual_machine_id || sel_ctrl;
		refused      = any_access && is_trace_reg && lock_ff;
		key_write    = req.wr && sel_key;
		reg_write    = req.wr && !refused;
	end

	// ***********************************************************
	// save-lock and sequence counter
	// ***********************************************************
	// the counter only steps while locked; a key write in the same
	// cycle wins, so every save or restore starts from zero
	always_comb begin
		nxt_lock = lock_ff;
		nxt_seq  = seq_ff;
		if (lock_ff && seq_step_i) begin
			nxt_seq = seq_ff + 8'h01; // save/restore step while locked
		end
		if (key_write) begin
			if (HAS_LOCK) begin
				nxt_lock = (req.wdata == LOCK_KEY_VALUE);
			end
			nxt_seq = SEQ_START;
		end
	end

	// lock comes out of reset set, so vm id and trace ctrl refuse access before software asks
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			lock_ff <= HAS_LOCK ? LOCK_RESET : 1'b0;
			seq_ff  <= SEQ_START;
		end else begin
			lock_ff <= nxt_lock;
			seq_ff  <= nxt_seq;
		end
	end

	// ***********************************************************
	// trace registers
	// ***********************************************************
	// only vm id and trace ctrl take writes; id ext, status and the
	// sequence counter ignore them, and a refused write is dropped
	always_comb begin
		nxt_virtual_machine_id = virtual_machine_id_ff;
		nxt_ctrl = ctrl_ff;
		if (reg_write && sel_virtual_machine_id && HAS_VIRT) begin
			nxt_virtual_machine_id = req.wdata[VIRTUAL_MACHINE_ID_W-1:0];
		end
		if (reg_write && sel_ctrl) begin
			nxt_ctrl = req.wdata;
		end
	end

	// trace register flops
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			virtual_machine_id_ff <= VIRTUAL_MACHINE_ID_RESET;
			ctrl_ff <= TRACE_CTRL_RESET;
		end else begin
			virtual_machine_id_ff <= nxt_virtual_machine_id;
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ***********************************************************
	// virtual machine id compare
	// ***********************************************************
	// exact compare with no mask, held off while powered down
	always_comb begin
		nxt_match = 1'b0;
		if (HAS_VIRT && !powered_down_i) begin
			nxt_match = (virtual_machine_id_current_i == virtual_machine_id_ff);
		end
	end

	// compare result flop, one cycle behind the inputs
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			match_ff <= 1'b0;
		end else begin
			match_ff <= nxt_match;
		end
	end

	// ***********************************************************
	// read words
	// ***********************************************************
	logic [31:0] status_word;
	logic [31:0] id_ext_word;
	logic [31:0] virtual_machine_id_word;
	logic [31:0] seq_word;

	// lock status word; without the lock it is all zero, which is
	// how software finds out that locking is absent
	always_comb begin
		status_word = ZERO_WORD;
		if (HAS_LOCK) begin
			status_word[IDX_LOCK_PD_HI] = PD_LEVEL_HI;
			status_word[IDX_LOCK_PD_LO] = PD_LEVEL_LO;
			status_word[IDX_LOCK_WIDE]  = 1'b0;
			status_word[IDX_LOCK_SET]   = lock_ff;
		end else begin
			status_word = ZERO_WORD;
		end
	end

	// identification extension word, fixed transfer orders
	always_comb begin
		id_ext_word                 = ZERO_WORD;
		id_ext_word[IDX_SWAP_ORDER] = SWAP_ORDER;
		id_ext_word[IDX_ERET_ORDER] = ERET_ORDER;
	end

	// narrow registers widened to a word, upper bits zero
	always_comb begin
		virtual_machine_id_word = ZERO_WORD;
		seq_word  = ZERO_WORD;
		if (HAS_VIRT) begin
			virtual_machine_id_word[VIRTUAL_MACHINE_ID_W-1:0] = virtual_machine_id_ff;
		end
		seq_word[7:0] = seq_ff;
	end

	// ***********************************************************
	// read mux and answer
	// ***********************************************************
	// answer for the next cycle; a refused access reads zero
	always_comb begin
		nxt_rsp       = '{rdata: ZERO_WORD, valid: 1'b0, error: 1'b0};
		nxt_rsp.valid = req.rd;
		nxt_rsp.error = refused;
		if (req.rd && !refused) begin
			if (sel_virtual_machine_id) begin
				nxt_rsp.rdata = virtual_machine_id_word;
			end else if (sel_id_ext) begin
				nxt_rsp.rdata = id_ext_word;
			end else if (sel_key) begin
				nxt_rsp.rdata = ZERO_WORD;
			end else if (sel_status) begin
				nxt_rsp.rdata = status_word;
			end else if (sel_ctrl) begin
				nxt_rsp.rdata = ctrl_ff;
			end else if (sel_seq) begin
				nxt_rsp.rdata = seq_word;
			end else begin
				nxt_rsp.rdata = ZERO_WORD; // unmapped reads zero
			end
		end
	end

	// answer flops; each field stands for one cycle only
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rsp_ff <= '{rdata: ZERO_WORD, valid: 1'b0, error: 1'b0};
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	// ***********************************************************
	// outputs
	// ***********************************************************
	// every output straight from a flop
	assign rdata_o      = rsp_ff.rdata;
	assign rvalid_o     = rsp_ff.valid;
	assign error_o      = rsp_ff.error;
	assign lock_o       = lock_ff;
	assign seq_count_o  = seq_ff;
	assign trace_ctrl_o = ctrl_ff;
	assign virtual_machine_id_match_o = match_ff;

endmodule

`default_nettype wire

// *** src/tolk_pkg.sv ***
// tolk_pkg: register offsets, field positions, reset values and types
// for the trace save-lock and identification register bank.
// assumes: 32-bit plain register port, word offsets chosen locally.
package tolk_pkg;
	localparam int          TOLK_AW           = 8;
	localparam int          TOLK_DW           = 32;
	// register byte offsets
	localparam logic [7:0]  OFF_VIRTUAL_MACHINE_ID_CMP      = 8'h00;
	localparam logic [7:0]  OFF_ID_EXT        = 8'h04;
	localparam logic [7:0]  OFF_LOCK_KEY      = 8'h08;
	localparam logic [7:0]  OFF_LOCK_STATUS   = 8'h0c;
	localparam logic [7:0]  OFF_TRACE_CTRL    = 8'h10;
	localparam logic [7:0]  OFF_SEQ_COUNT     = 8'h14;
	// key value that sets the lock
	localparam logic [31:0] LOCK_KEY_VALUE    = 32'hc5acce55;
	// field positions
	localparam int          VIRTUAL_MACHINE_ID_W            = 8;
	localparam int          IDX_SWAP_ORDER    = 1;
	localparam int          IDX_ERET_ORDER    = 0;
	localparam int          IDX_LOCK_PD_HI    = 3;
	localparam int          IDX_LOCK_WIDE     = 2;
	localparam int          IDX_LOCK_SET      = 1;
	localparam int          IDX_LOCK_PD_LO    = 0;
	// reset values
	localparam logic [7:0]  VIRTUAL_MACHINE_ID_RESET        = 8'h00;
	localparam logic [31:0] TRACE_CTRL_RESET  = 32'h00000000;
	localparam logic [7:0]  SEQ_START         = 8'h00;
	localparam logic        LOCK_RESET        = 1'b1;
	localparam logic [31:0] ZERO_WORD         = 32'h00000000;

	// one register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tolk_req_t;

	// one register port answer
	typedef struct packed {
		logic [31:0] rdata;
		logic        valid;
		logic        error;
	} tolk_rsp_t;
endpackage

// *** bench/tolk_regs_properties.sv ***
// checker: port properties of the save-lock register bank
// assumes: bound to tolk_regs, one clock, default parameters
`timescale 1ns/1ps
`default_nettype none
module tolk_regs_properties
	import tolk_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        error_o,
	input wire logic        lock_o,
	input wire logic [7:0]  seq_count_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// key register write decode
	wire key_wr = wr_i && addr_i == OFF_LOCK_KEY;
	wire trc_ac = (wr_i || rd_i) && (addr_i == OFF_VIRTUAL_MACHINE_ID_CMP || addr_i == OFF_TRACE_CTRL);
	key_lock_a: assert property (key_wr && wdata_i == LOCK_KEY_VALUE |=> lock_o)
		else $error("key write left lock clear");
	key_unlock_a: assert property (key_wr && wdata_i != LOCK_KEY_VALUE |=> !lock_o)
		else $error("other write left lock set");
	lock_err_a: assert property (trc_ac && lock_o |=> error_o && rdata_o == ZERO_WORD)
		else $error("locked access not refused");
	open_ok_a: assert property ((wr_i || rd_i) && !lock_o |=> !error_o)
		else $error("unlocked access refused");
	seq_clr_a: assert property (key_wr |=> seq_count_o == SEQ_START)
		else $error("sequence counter not restarted");
	key_rd_a: assert property (rd_i && addr_i == OFF_LOCK_KEY |=> rdata_o == ZERO_WORD)
		else $error("key register readable");
	stat_rd_a: assert property (rd_i && addr_i == OFF_LOCK_STATUS |=>
		rdata_o[31:4] == 28'h0 && !rdata_o[2] && rdata_o[1] == $past(lock_o))
		else $error("lock status word wrong");
	virtual_machine_id_rd_a: assert property (rd_i && addr_i == OFF_VIRTUAL_MACHINE_ID_CMP |=> rdata_o[31:8] == 24'h0)
		else $error("vm id upper bits set");
	idx_rd_a: assert property (rd_i && addr_i == OFF_ID_EXT |=> rdata_o[31:2] == 30'h0)
		else $error("id extension reserved bits set");
	rst_lock_a: assert property ($fell(reset_i) |-> lock_o)
		else $error("lock clear after reset");
endmodule
bind tolk_regs tolk_regs_properties tolk_regs_properties_i (.clk_sys_i, .reset_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .error_o, .lock_o, .seq_count_o);
`default_nettype wire

// *** bench/tolk_regs_tb.sv ***
// bench: register access sequences for the save-lock bank
// assumes: tolk_regs with default parameters, checker bound beside it
`timescale 1ns/1ps
`default_nettype none
module tolk_regs_tb
	import tolk_pkg::*;
;
	logic        clk_sys_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, seq_step_i = 1'b0;
	logic [7:0]  addr_i = 8'h00, virtual_machine_id_current_i = 8'ha5, seq_count_o;
	logic [31:0] wdata_i = 32'h0, rdata_o, trace_ctrl_o;
	logic        rvalid_o, error_o, lock_o, virtual_machine_id_match_o;
	logic        powered_down_i = 1'b0;
	int          fails = 0;
	int          comparisons = 0;
	tolk_regs tolk_regs_i (.clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .seq_step_i,
		.powered_down_i, .virtual_machine_id_current_i, .rdata_o, .rvalid_o, .error_o, .lock_o,
		.seq_count_o, .trace_ctrl_o, .virtual_machine_id_match_o);
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one write (w=1) or read, answer checked in the following cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= !w;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1;
		chk({31'h0, error_o}, {31'h0, e});
		chk({31'h0, rvalid_o}, {31'h0, !w});
		if (!w) chk(rdata_o, d);
	endtask
	task automatic test_done();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// hang guard
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		fails++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		acc(1'b0, OFF_LOCK_STATUS, 32'h00000003, 1'b0);
		acc(1'b0, OFF_LOCK_KEY, ZERO_WORD, 1'b0);
		acc(1'b0, OFF_ID_EXT, ZERO_WORD, 1'b0);
		acc(1'b1, OFF_VIRTUAL_MACHINE_ID_CMP, 32'h000000a5, 1'b1);
		acc(1'b0, OFF_TRACE_CTRL, ZERO_WORD, 1'b1);
		@(posedge clk_sys_i);
		seq_step_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		seq_step_i <= 1'b0;
		acc(1'b0, OFF_SEQ_COUNT, 32'h00000003, 1'b0);
		acc(1'b1, OFF_LOCK_KEY, ZERO_WORD, 1'b0);
		chk({24'h0, seq_count_o}, {24'h0, SEQ_START});
		acc(1'b0, OFF_SEQ_COUNT, {24'h0, SEQ_START}, 1'b0);
		acc(1'b0, OFF_LOCK_STATUS, 32'h00000001, 1'b0);
		acc(1'b1, OFF_VIRTUAL_MACHINE_ID_CMP, 32'hffffffa5, 1'b0);
		acc(1'b0, OFF_VIRTUAL_MACHINE_ID_CMP, 32'h000000a5, 1'b0);
		chk({31'h0, virtual_machine_id_match_o}, 32'h1);
		powered_down_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk({31'h0, virtual_machine_id_match_o}, 32'h0);
		powered_down_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk({31'h0, virtual_machine_id_match_o}, 32'h1);
		virtual_machine_id_current_i <= 8'h25;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk({31'h0, virtual_machine_id_match_o}, 32'h0);
		acc(1'b1, OFF_TRACE_CTRL, 32'h12345678, 1'b0);
		acc(1'b1, OFF_ID_EXT, 32'hffffffff, 1'b0);
		acc(1'b0, OFF_ID_EXT, ZERO_WORD, 1'b0);
		acc(1'b1, OFF_LOCK_STATUS, 32'hffffffff, 1'b0);
		acc(1'b0, OFF_LOCK_STATUS, 32'h00000001, 1'b0);
		acc(1'b1, OFF_LOCK_KEY, LOCK_KEY_VALUE, 1'b0);
		acc(1'b1, OFF_TRACE_CTRL, ZERO_WORD, 1'b1);
		chk(trace_ctrl_o, 32'h12345678);
		acc(1'b0, 8'hf0, ZERO_WORD, 1'b0);
		acc(1'b1, OFF_LOCK_KEY, 32'hc5acce54, 1'b0);
		acc(1'b0, OFF_LOCK_STATUS, 32'h00000001, 1'b0);
		reset_i <= 1'b1;
		@(posedge clk_sys_i);
		reset_i <= 1'b0;
		acc(1'b0, OFF_LOCK_STATUS, 32'h00000003, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
